// file: rtl/rpis_defines.svh
// register offsets, field positions and reset values of the receive-port interrupt status block
`ifndef RPIS_DEFINES_SVH
`define RPIS_DEFINES_SVH

// global register
`define RPIS_ADDR_PORT_SEL   8'h4c
`define RPIS_RST_PORT_SEL    8'h00
`define RPIS_MASK_PORT_SEL   8'h01

// per-port registers whose reads clear status
`define RPIS_ADDR_RX_STS1    8'h4d
`define RPIS_ADDR_RX_STS2    8'h4e
`define RPIS_ADDR_CSI_STS    8'h7a
`define RPIS_ADDR_SEN_RISE   8'hde
`define RPIS_ADDR_SEN_FALL   8'hdf

// per-port interrupt enable and status registers
`define RPIS_ADDR_ICR_HI     8'hd8
`define RPIS_ADDR_ICR_LO     8'hd9
`define RPIS_ADDR_ISR_HI     8'hda
`define RPIS_ADDR_ISR_LO     8'hdb
`define RPIS_ADDR_GPIO_STS   8'hdc
`define RPIS_ADDR_GPIO_ICR   8'hdd

// reset values and writable masks
`define RPIS_RST_ICR_HI      8'h00
`define RPIS_MASK_ICR_HI     8'h07
`define RPIS_RST_ICR_LO      8'h00
`define RPIS_MASK_ICR_LO     8'hff
`define RPIS_RST_ISR_HI      5'h00
`define RPIS_RST_ISR_LO      7'h00
`define RPIS_RST_GPIO_EVT    4'h0
`define RPIS_RST_GPIO_ICR    8'h00
`define RPIS_RST_RDATA       8'h00

// high status bit positions
`define RPIS_HI_GPIO         4
`define RPIS_HI_SENSOR       3
`define RPIS_HI_ENC          2
`define RPIS_HI_SEQ          1
`define RPIS_HI_CRC          0

// low status bit positions
`define RPIS_LO_LINE_LEN     6
`define RPIS_LO_LINE_CNT     5
`define RPIS_LO_OVERFLOW     4
`define RPIS_LO_CSI          3
`define RPIS_LO_PARITY       2
`define RPIS_LO_VALID        1
`define RPIS_LO_LOCK         0

// forward gpio status layout
`define RPIS_GPIO_EVT_LSB    4
`define RPIS_GPIO_LVL_LSB    0

`endif

// file: rtl/rpis_pkg.sv
// types shared by the receive-port interrupt status block
package rpis_pkg;

	localparam int RPIS_PORTS = 2;
	localparam int RPIS_GPIOS = 4;

	// register access request from the i2c target
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} rpis_req_t;

	// per-port event pulses and levels from the receive logic
	typedef struct packed {
		logic link_encoding_error;
		logic ctrl_sequence_error;
		logic ctrl_crc_error;
		logic video_line_length_changed;
		logic video_line_count_changed;
		logic rx_overflow;
		logic camera_rx_error;
		logic link_parity_error;
		logic sensor_change;
		logic port_valid;
		logic lock_state;
	} rpis_evt_t;

endpackage

// file: rtl/rpis_sync.sv
// three-stage synchroniser that passes a change once stages two and three agree
module rpis_sync
	import rpis_pkg::*;
#(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// asynchronous in, settled out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] agree;
	logic [W-1:0] q_next;

	// a bit still moving between stages holds the old value
	assign agree  = ~(s2_reg ^ s3_reg);
	assign q_next = (s3_reg & agree) | (q & ~agree);

	// first stage feeds only the second
	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q      <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q      <= q_next;
		end
	end

endmodule // rpis_sync

// file: rtl/rpis_top.sv
// receive-port interrupt status: per-port latched events, gpio flags and i2c register access
//
// Notes on behaviour
// [RL1] each receive port has its own copy; register 0x4c picks the port reached
// [RL2] high bit 4 sets on forward gpio change, clears on reading gpio status
// [RL3] high bit 3 sets on sensor change, clears after both sensor status reads
// [RL4] high bit 2 sets on link encoding error, clears on reading port status two
// [RL5] high bit 1 sets on control sequence error, clears on reading port status one
// [RL6] high bit 0 sets on control crc error, clears on reading port status one
// [RL7] low bit 6 sets on line length change, clears on reading port status two
// [RL8] low bit 5 sets on line count change, clears on reading port status two
// [RL9] low bit 4 sets on receive overflow, clears on reading port status two
// [RL10] low bit 3 sets on camera receiver error, clears on reading register 0x7a
// [RL11] low bit 2 sets on link parity error, clears on reading port status one
// [RL12] low bit 1 sets on port valid change, clears on reading port status one
// [RL13] low bit 0 sets on lock change, clears on reading port status one
// [RL14] gpio status bits 7..4 flag gpio 3..0 events, cleared by reading it
// [RL15] gpio status bits 3..0 show live gpio 3..0 levels, no read effect
// [RL16] a status bit raises the interrupt only when its enable bit is set, except high bits 4 and 3, which always do
// [RL17] a gpio edge counts only when its rise or fall enable is set
// [RL18] status holds until its clearing read; a same-cycle event wins
// [RL19] enabled set bits of a port merge into one level interrupt request
`include "rpis_defines.svh"

module rpis_top
	import rpis_pkg::*;
(
	// clock and reset
	input  wire logic                                mclk,
	input  wire logic                                rst,
	// register access from the i2c target
	input  wire rpis_req_t                           reg_req,
	output logic                   [7:0]             reg_rdata,
	// receive logic events per port
	input  wire rpis_evt_t         [RPIS_PORTS-1:0]  port_evt,
	// forward-channel gpio levels per port, link timing
	input  wire logic [RPIS_PORTS-1:0][RPIS_GPIOS-1:0] fwd_io,
	// interrupt request per port
	output logic                   [RPIS_PORTS-1:0]  port_irq
);

	////////////////////////////////////////////////////////////////////////////
	// port select register

	logic [7:0] port_sel_reg;
	logic [7:0] port_sel_next;
	logic       wr_port_sel;
	logic       rd_port_sel;

	assign wr_port_sel   = reg_req.wr && (reg_req.addr == `RPIS_ADDR_PORT_SEL);
	assign rd_port_sel   = reg_req.rd && (reg_req.addr == `RPIS_ADDR_PORT_SEL);
	assign port_sel_next = wr_port_sel ? (reg_req.wdata & `RPIS_MASK_PORT_SEL) : port_sel_reg;

	// only bit 0 is kept: two ports need a single select bit
	// selects which port copy the host reaches
	always_ff @(posedge mclk) begin
		if (rst) begin
			port_sel_reg <= `RPIS_RST_PORT_SEL;
		end else begin
			port_sel_reg <= port_sel_next; // RL1
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// gpio level synchroniser

	logic [RPIS_PORTS-1:0][RPIS_GPIOS-1:0] io_lvl;

	// gpio levels come from the link side, so they need a crossing
	// the crossing costs about four edges before a level or an edge is seen
	rpis_sync #(
		.W (RPIS_PORTS * RPIS_GPIOS)
	) u_io_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    (fwd_io),
		.q    (io_lvl)
	);

	////////////////////////////////////////////////////////////////////////////
	// per-port status logic

	logic [RPIS_PORTS-1:0][7:0] port_rdata;
	logic [RPIS_PORTS-1:0]      port_hit;

	// one copy per port; the select bit lets only one copy answer the bus
	for (genvar p = 0; p < RPIS_PORTS; p++) begin : g_port

		logic       me;
		logic       rd_sts1;
		logic       rd_sts2;
		logic       rd_csi;
		logic       rd_rise;
		logic       rd_fall;
		logic       rd_gsts;
		logic       rd_icr_hi;
		logic       rd_icr_lo;
		logic       rd_isr_hi;
		logic       rd_isr_lo;
		logic       rd_gicr;
		logic       wr_icr_hi;
		logic       wr_icr_lo;
		logic       wr_gicr;
		logic [7:0] icr_hi_reg;
		logic [7:0] icr_hi_next;
		logic [7:0] icr_lo_reg;
		logic [7:0] icr_lo_next;
		logic [7:0] gicr_reg;
		logic [7:0] gicr_next;
		logic [4:0] hi_reg;
		logic [4:0] hi_next;
		logic [4:0] hi_set;
		logic [4:0] hi_clr;
		logic [4:0] hi_en;
		logic [6:0] lo_reg;
		logic [6:0] lo_next;
		logic [6:0] lo_set;
		logic [6:0] lo_clr;
		logic [3:0] gev_reg;
		logic [3:0] gev_next;
		logic [3:0] gev_set;
		logic [3:0] lvl_prev_reg;
		logic [3:0] rise;
		logic [3:0] fall;
		logic       rise_seen_reg;
		logic       rise_seen_next;
		logic       fall_seen_reg;
		logic       fall_seen_next;
		logic       sensor_clr;
		logic       valid_prev_reg;
		logic       lock_prev_reg;
		logic       irq_reg;
		logic       irq_next;

		// address decode for this port's copy
		assign me        = (port_sel_reg[0] == 1'(p)); // RL1
		assign rd_sts1   = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_RX_STS1);
		assign rd_sts2   = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_RX_STS2);
		assign rd_csi    = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_CSI_STS);
		assign rd_rise   = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_SEN_RISE);
		assign rd_fall   = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_SEN_FALL);
		assign rd_gsts   = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_GPIO_STS);
		assign rd_icr_hi = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_ICR_HI);
		assign rd_icr_lo = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_ICR_LO);
		assign rd_isr_hi = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_ISR_HI);
		assign rd_isr_lo = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_ISR_LO);
		assign rd_gicr   = me && reg_req.rd && (reg_req.addr == `RPIS_ADDR_GPIO_ICR);
		assign wr_icr_hi = me && reg_req.wr && (reg_req.addr == `RPIS_ADDR_ICR_HI);
		assign wr_icr_lo = me && reg_req.wr && (reg_req.addr == `RPIS_ADDR_ICR_LO);
		assign wr_gicr   = me && reg_req.wr && (reg_req.addr == `RPIS_ADDR_GPIO_ICR);

		// high and low interrupt enables gate only the request; status bits latch whatever those enables say
		// enable registers; reserved bits 7..3 of the high enable stay zero
		assign icr_hi_next = wr_icr_hi ? (reg_req.wdata & `RPIS_MASK_ICR_HI) : icr_hi_reg;
		assign icr_lo_next = wr_icr_lo ? (reg_req.wdata & `RPIS_MASK_ICR_LO) : icr_lo_reg;
		assign gicr_next   = wr_gicr ? reg_req.wdata : gicr_reg;

		// previous levels reset low, so a gpio high at release gives one rising edge
		// gpio edges, each gated by its own enable
		for (genvar n = 0; n < RPIS_GPIOS; n++) begin : g_io
			assign rise[n]    = io_lvl[p][n] & ~lvl_prev_reg[n];
			assign fall[n]    = ~io_lvl[p][n] & lvl_prev_reg[n];
			assign gev_set[n] = (rise[n] & gicr_reg[2*n]) | (fall[n] & gicr_reg[2*n+1]); // RL17
		end

		// flags clear on the status read, an event in that cycle survives
		assign gev_next = (gev_reg & ~{RPIS_GPIOS{rd_gsts}}) | gev_set; // RL14 RL18

		// sensor bit waits for both rise and fall status reads since it was set
		// a new sensor event restarts the tracking so reads taken before it do not count
		assign sensor_clr     = (rise_seen_reg | rd_rise) & (fall_seen_reg | rd_fall); // RL3
		assign rise_seen_next = (hi_set[`RPIS_HI_SENSOR] | sensor_clr) ? 1'b0 : (rise_seen_reg | rd_rise);
		assign fall_seen_next = (hi_set[`RPIS_HI_SENSOR] | sensor_clr) ? 1'b0 : (fall_seen_reg | rd_fall);

		// high status set sources
		assign hi_set[`RPIS_HI_GPIO]   = |gev_set;                         // RL2
		assign hi_set[`RPIS_HI_SENSOR] = port_evt[p].sensor_change;        // RL3
		assign hi_set[`RPIS_HI_ENC]    = port_evt[p].link_encoding_error;  // RL4
		assign hi_set[`RPIS_HI_SEQ]    = port_evt[p].ctrl_sequence_error;  // RL5
		assign hi_set[`RPIS_HI_CRC]    = port_evt[p].ctrl_crc_error;       // RL6

		// high status clearing reads
		assign hi_clr[`RPIS_HI_GPIO]   = rd_gsts;    // RL2
		assign hi_clr[`RPIS_HI_SENSOR] = sensor_clr; // RL3
		assign hi_clr[`RPIS_HI_ENC]    = rd_sts2;    // RL4
		assign hi_clr[`RPIS_HI_SEQ]    = rd_sts1;    // RL5
		assign hi_clr[`RPIS_HI_CRC]    = rd_sts1;    // RL6

		// valid and lock history reset low: a high level at release flags one change
		// low status set sources; level inputs flag any change
		assign lo_set[`RPIS_LO_LINE_LEN] = port_evt[p].video_line_length_changed;    // RL7
		assign lo_set[`RPIS_LO_LINE_CNT] = port_evt[p].video_line_count_changed;     // RL8
		assign lo_set[`RPIS_LO_OVERFLOW] = port_evt[p].rx_overflow;                  // RL9
		assign lo_set[`RPIS_LO_CSI]      = port_evt[p].camera_rx_error;              // RL10
		assign lo_set[`RPIS_LO_PARITY]   = port_evt[p].link_parity_error;            // RL11
		assign lo_set[`RPIS_LO_VALID]    = port_evt[p].port_valid ^ valid_prev_reg;  // RL12
		assign lo_set[`RPIS_LO_LOCK]     = port_evt[p].lock_state ^ lock_prev_reg;   // RL13

		// low status clearing reads
		assign lo_clr[`RPIS_LO_LINE_LEN] = rd_sts2; // RL7
		assign lo_clr[`RPIS_LO_LINE_CNT] = rd_sts2; // RL8
		assign lo_clr[`RPIS_LO_OVERFLOW] = rd_sts2; // RL9
		assign lo_clr[`RPIS_LO_CSI]      = rd_csi;  // RL10
		assign lo_clr[`RPIS_LO_PARITY]   = rd_sts1; // RL11
		assign lo_clr[`RPIS_LO_VALID]    = rd_sts1; // RL12
		assign lo_clr[`RPIS_LO_LOCK]     = rd_sts1; // RL13

		// set wins over clear so no event is lost
		assign hi_next = (hi_reg & ~hi_clr) | hi_set; // RL18
		assign lo_next = (lo_reg & ~lo_clr) | lo_set; // RL18

		// gpio and sensor bits have no enable here and always count; only gpio is gated upstream
		assign hi_en = {2'b11, icr_hi_reg[2:0]};

		// one level request per port, dropping once no enabled bit is set
		// registered so the request never glitches, at the cost of one edge of delay
		assign irq_next = |(hi_reg & hi_en) | |(lo_reg & icr_lo_reg[6:0]); // RL16 RL19

		// read data for this port; of these registers only the gpio status read clears anything
		assign port_rdata[p] = rd_icr_hi ? icr_hi_reg :
		                       rd_icr_lo ? icr_lo_reg :
		                       rd_isr_hi ? {3'h0, hi_reg} :
		                       rd_isr_lo ? {1'b0, lo_reg} :
		                       rd_gsts   ? {gev_reg, io_lvl[p]} : // RL14 RL15
		                       rd_gicr   ? gicr_reg : 8'h00;
		assign port_hit[p]   = rd_icr_hi | rd_icr_lo | rd_isr_hi | rd_isr_lo | rd_gsts | rd_gicr;

		// enable registers
		always_ff @(posedge mclk) begin
			if (rst) begin
				icr_hi_reg <= `RPIS_RST_ICR_HI;
				icr_lo_reg <= `RPIS_RST_ICR_LO;
				gicr_reg   <= `RPIS_RST_GPIO_ICR;
			end else begin
				icr_hi_reg <= icr_hi_next;
				icr_lo_reg <= icr_lo_next;
				gicr_reg   <= gicr_next;
			end
		end

		// latched status and sensor read tracking
		always_ff @(posedge mclk) begin
			if (rst) begin
				hi_reg        <= `RPIS_RST_ISR_HI;
				lo_reg        <= `RPIS_RST_ISR_LO;
				gev_reg       <= `RPIS_RST_GPIO_EVT;
				rise_seen_reg <= 1'b0;
				fall_seen_reg <= 1'b0;
			end else begin
				hi_reg        <= hi_next;
				lo_reg        <= lo_next;
				gev_reg       <= gev_next;
				rise_seen_reg <= rise_seen_next;
				fall_seen_reg <= fall_seen_next;
			end
		end

		// previous levels for change detection and the registered request
		always_ff @(posedge mclk) begin
			if (rst) begin
				lvl_prev_reg   <= 4'h0;
				valid_prev_reg <= 1'b0;
				lock_prev_reg  <= 1'b0;
				irq_reg        <= 1'b0;
			end else begin
				lvl_prev_reg   <= io_lvl[p];
				valid_prev_reg <= port_evt[p].port_valid;
				lock_prev_reg  <= port_evt[p].lock_state;
				irq_reg        <= irq_next; // RL19
			end
		end

		assign port_irq[p] = irq_reg;

	end

	////////////////////////////////////////////////////////////////////////////
	// read data return

	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;
	logic [7:0] port_pick;

	// clearing-only offsets read as zero here; their contents live in other blocks
	// only the selected port decodes, so an or of both copies is safe
	assign port_pick  = port_rdata[0] | port_rdata[1];
	assign rdata_next = rd_port_sel ? port_sel_reg :
	                    (|port_hit) ? port_pick :
	                    reg_req.rd  ? 8'h00 : rdata_reg;

	// data holds until the next read so the i2c target may shift it out slowly
	// a write leaves the held read data untouched
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_reg <= `RPIS_RST_RDATA;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

endmodule // rpis_top

// file: verification/rpis_asserts.sv
// port-level assertions for the receive-port interrupt status block
module rpis_chk
	import rpis_pkg::*;
(
	// clock and reset
	input wire logic                                  mclk,
	input wire logic                                  rst,
	// register access
	input wire rpis_req_t                             reg_req,
	input wire logic [7:0]                            reg_rdata,
	// events, gpio levels and interrupts
	input wire rpis_evt_t [RPIS_PORTS-1:0]            port_evt,
	input wire logic [RPIS_PORTS-1:0][RPIS_GPIOS-1:0] fwd_io,
	input wire logic [RPIS_PORTS-1:0]                 port_irq
);
	timeunit 1ns;
	timeprecision 1ps;

	logic sel_reg;
	logic crc_en_reg;
	wire  rd0 = reg_req.rd && !sel_reg;

	////////////////////////////////////////////////////////////
	// shadow of the port select and of port 0 crc enable, so properties can stay on port 0
	always_ff @(posedge mclk) begin
		if (rst) begin
			sel_reg    <= 1'b0;
			crc_en_reg <= 1'b0;
		end else if (reg_req.wr && reg_req.addr == 8'h4c) begin
			sel_reg <= reg_req.wdata[0];
		end else if (reg_req.wr && reg_req.addr == 8'hd8 && !sel_reg) begin
			crc_en_reg <= reg_req.wdata[0];
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// lock and valid steady, no parity pulse: nothing may re-set low bits 2..0
	sequence s_quiet;
		$stable(port_evt[0].lock_state) && $stable(port_evt[0].port_valid) && !port_evt[0].link_parity_error;
	endsequence

	////////////////////////////////////////////////////////////
	AST_CRC_SET: assert property (port_evt[0].ctrl_crc_error ##1 rd0 && reg_req.addr == 8'hda |=> reg_rdata[0])
		else $error("crc status not latched");
	AST_LEN_SET: assert property (port_evt[0].video_line_length_changed ##1 rd0 && reg_req.addr == 8'hdb |=> reg_rdata[6])
		else $error("line length status not latched");
	AST_SET_WINS: assert property ((port_evt[0].ctrl_crc_error && rd0 && reg_req.addr == 8'h4d) ##2
		rd0 && reg_req.addr == 8'hda |=> reg_rdata[0])
		else $error("clearing read beat a new event");
	AST_CLR_ONE: assert property ((rd0 && reg_req.addr == 8'h4d) ##0 s_quiet[*2] ##1 rd0 && reg_req.addr == 8'hdb |=> reg_rdata[2:0] == 3'h0)
		else $error("low status not cleared by port status one read");
	AST_IRQ_CRC: assert property (port_evt[0].ctrl_crc_error && crc_en_reg |-> ##2 port_irq[0])
		else $error("enabled event gave no interrupt");
	AST_LVL: assert property ($stable(fwd_io[0]) [*6] ##0 rd0 && reg_req.addr == 8'hdc |=> reg_rdata[3:0] == $past(fwd_io[0]))
		else $error("gpio level not live");
	AST_SEL_RB: assert property (reg_req.wr && reg_req.addr == 8'h4c ##2 reg_req.rd && reg_req.addr == 8'h4c
		|=> reg_rdata == {7'h00, $past(reg_req.wdata[0], 3)})
		else $error("port select readback wrong");
	AST_ICR_RB: assert property (reg_req.wr && reg_req.addr == 8'hd8 ##2 reg_req.rd && reg_req.addr == 8'hd8
		|=> reg_rdata == {5'h00, $past(reg_req.wdata[2:0], 3)})
		else $error("high enable readback wrong");
	AST_RST_IRQ: assert property ($fell(rst) |-> port_irq == '0 && reg_rdata == 8'h00)
		else $error("outputs not quiet after reset");
endmodule // rpis_chk

// file: verification/rpis_host.sv
// host model: single-byte register reads and writes on the access request
module rpis_host
	import rpis_pkg::*;
(
	// clock
	input wire logic       mclk,
	// request out, data back
	output rpis_req_t      reg_req,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial reg_req = '0;

	////////////////////////////////////////////////////////////
	// called at a falling edge; the spare cycle keeps a strobe from being raised twice in one step
	// released address and data are inverted so nothing downstream can lean on stale values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge mclk);
		reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
		@(negedge mclk);
	endtask

	// read data is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge mclk);
		reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
		d = reg_rdata;
		@(negedge mclk);
	endtask
endmodule // rpis_host

// file: verification/rx_port_interrupt_status_tb_top.sv
// testbench top for the receive-port interrupt status block
module rx_port_interrupt_status_tb_top
	import rpis_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end

	logic                                  mclk;
	logic                                  rst;
	rpis_req_t                             reg_req;
	logic [7:0]                            reg_rdata;
	rpis_evt_t [RPIS_PORTS-1:0]            port_evt;
	logic [RPIS_PORTS-1:0][RPIS_GPIOS-1:0] fwd_io;
	logic [RPIS_PORTS-1:0]                 port_irq;
	logic [7:0]                            d;
	int                                    n_fail;
	int                                    n_compared;
	int                                    cyc;
	// per event bit: status register, bit, a read that must not clear, the read that clears
	logic [7:0] ra [8]  = '{8'h4c, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hdd, 8'h10};
	logic [7:0] sa [11] = '{8'hdb, 8'hdb, 8'hda, 8'hdb, 8'hdb, 8'hdb, 8'hdb, 8'hdb, 8'hda, 8'hda, 8'hda};
	int         sb [11] = '{0, 1, 3, 2, 3, 4, 5, 6, 0, 1, 2};
	logic [7:0] c1 [11] = '{8'h4e, 8'h4e, 8'hde, 8'h4e, 8'h4d, 8'h4d, 8'h4d, 8'h4d, 8'h4e, 8'h4e, 8'h4d};
	logic [7:0] c2 [11] = '{8'h4d, 8'h4d, 8'hdf, 8'h4d, 8'h7a, 8'h4e, 8'h4e, 8'h4e, 8'h4d, 8'h4d, 8'h4e};

	rpis_top dut (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .port_evt(port_evt),
		.fwd_io(fwd_io), .port_irq(port_irq));
	rpis_host host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata));

	////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// hang guard: the tests need well under a thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// pulses return low; the two level inputs just toggle and stay
	task automatic pulse(input int p, input int k);
		port_evt[p][k] = ~port_evt[p][k];
		@(negedge mclk);
		if (k > 1)
			port_evt[p][k] = 1'b0;
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		port_evt = '0;
		fwd_io = '0;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		// reset values, with one unmapped offset
		foreach (ra[i]) begin
			host.rd(ra[i], d);
			`CHK(d, 8'h00)
		end
		$display("test reset done");
		// every event: set, survive a foreign read, clear on its own read, interrupt follows
		host.wr(8'hd8, 8'h07);
		host.wr(8'hd9, 8'h7f);
		for (int k = 0; k < 11; k++) begin
			pulse(0, k);
			host.rd(sa[k], d);
			`CHK(d, 8'h01 << sb[k])
			`CHK(port_irq[0], 1'b1)
			host.rd(c1[k], d);
			host.rd(sa[k], d);
			`CHK(d, 8'h01 << sb[k])
			host.rd(c2[k], d);
			host.rd(sa[k], d);
			`CHK(d, 8'h00)
			`CHK(port_irq[0], 1'b0)
		end
		$display("test events done");
		// an event on the same edge as its clearing read survives
		port_evt[0].ctrl_crc_error = 1'b1;
		fork
			host.rd(8'h4d, d);
			begin
				@(negedge mclk);
				port_evt[0].ctrl_crc_error = 1'b0;
			end
		join
		host.rd(8'hda, d);
		`CHK(d, 8'h01)
		host.rd(8'h4d, d);
		$display("test collision done");
		// second port: own status copy, own enables
		host.wr(8'h4c, 8'h01);
		host.rd(8'h4c, d);
		`CHK(d, 8'h01)
		pulse(1, 8);
		host.rd(8'hda, d);
		`CHK(d, 8'h01)
		`CHK(port_irq, 2'b00)
		host.wr(8'hd8, 8'h01);
		host.rd(8'hd8, d);
		`CHK(d, 8'h01)
		`CHK(port_irq, 2'b10)
		host.rd(8'h4d, d);
		host.wr(8'h4c, 8'h00);
		host.rd(8'hda, d);
		`CHK(d, 8'h00)
		$display("test port select done");
		// gpio: only enabled edges flag, levels read live
		host.wr(8'hdd, 8'h01);
		fwd_io[0] = 4'h3;
		repeat (8) @(negedge mclk);
		host.rd(8'hda, d);
		`CHK(d, 8'h10)
		`CHK(port_irq[0], 1'b1)
		host.rd(8'hdc, d);
		`CHK(d, 8'h13)
		host.rd(8'hdc, d);
		`CHK(d, 8'h03)
		host.rd(8'hda, d);
		`CHK(d, 8'h00)
		host.wr(8'hdd, 8'h08);
		fwd_io[0] = 4'h0;
		repeat (8) @(negedge mclk);
		host.rd(8'hdc, d);
		`CHK(d, 8'h20)
		$display("test gpio done");
		give_verdict();
	end
endmodule // rx_port_interrupt_status_tb_top

bind rpis_top rpis_chk u_chk (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.port_evt(port_evt), .fwd_io(fwd_io), .port_irq(port_irq));
